/* File: rtl/ercs_cfg.svh */
// configuration macros for the receive client stream
`ifndef ERCS_CFG_SVH
`define ERCS_CFG_SVH
`define ERCS_WORDS 5
`define ERCS_BYTES (`ERCS_WORDS * 8)
`define ERCS_CH_IDLE 8'h07
`define ERCS_CH_START 8'hfb
`define ERCS_CH_TERM 8'hfd
`define ERCS_CH_ERROR 8'hfe
`define ERCS_CH_PRE 8'h55
`define ERCS_PRE_BYTES 3'h7
`define ERCS_MIN_LEN 16'h0040
`define ERCS_DECODE_LEN 16'h0008
`define ERCS_CRC_INIT 32'hffffffff
`define ERCS_CRC_POLY 32'hedb88320
`define ERCS_CRC_RESIDUE 32'hdebb20e3
`define ERCS_MAXLEN_RST 16'h05ee
`define ERCS_FLT_ENA_BIT 30
`define ERCS_FLT_CMP_BIT 0
`define ERCS_MODE_PASS_BIT 0
`define ERCS_REG_FILTER 8'h00
`define ERCS_REG_ADDR_LOW 8'h04
`define ERCS_REG_ADDR_HIGH 8'h08
`define ERCS_REG_MAXLEN 8'h0c
`define ERCS_REG_MODE 8'h10
`define ERCS_REG_STATUS 8'h14
`define ERCS_REG_MASK 8'h18
`define ERCS_ST_CRC 0
`define ERCS_ST_RUNT 1
`define ERCS_ST_LONG 2
`define ERCS_ST_DECODE 3
`define ERCS_ST_BITS 4
`endif

/* File: rtl/ercs_client_end.sv */
// client end: qualifies the stream and hands payload words to user logic
`timescale 1ns/100ps
`include "ercs_cfg.svh"
module ercs_client_end (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // stream from the mac
    ercs_if.client rx,
    // user options
    input wire logic keepNonPayload,
    // user side words
    output logic [`ERCS_BYTES*8-1:0] usrData,
    output logic [`ERCS_BYTES-1:0] usrCtl,
    output logic [`ERCS_WORDS-1:0] usrKeep,
    output logic [`ERCS_WORDS-1:0] usrFirst,
    output logic [`ERCS_BYTES-1:0] usrLast,
    output logic [`ERCS_WORDS-1:0] usrDestHit,
    output logic [`ERCS_WORDS-1:0] usrRunt,
    output logic usrValid,
    // user side frame results
    output logic usrFrameEnd,
    output logic usrCrcBad,
    output logic usrRxError,
    output logic [15:0] usrFrameCount,
    output logic [15:0] usrBadCount
);
    logic [`ERCS_BYTES*8-1:0] data_q, data_d;
    logic [`ERCS_BYTES-1:0] ctl_q, ctl_d, last_q, last_d;
    logic [`ERCS_WORDS-1:0] keep_q, keep_d, first_q, first_d, hit_q, hit_d, runt_q, runt_d;
    logic valid_q, valid_d, end_q, end_d, crcBad_q, crcBad_d, rxErr_q, rxErr_d;
    logic [15:0] frames_q, frames_d, bad_q, bad_d;
    logic [`ERCS_WORDS-1:0] keep;
    logic ok;

    always_comb
    begin
        ok = rx.beat.valid;
        // without custom content only payload words matter, control flags are dropped
        keep = rx.beat.payload | {`ERCS_WORDS{keepNonPayload}};
        data_d = data_q;
        ctl_d = ctl_q;
        keep_d = '0;
        first_d = '0;
        last_d = '0;
        hit_d = '0;
        runt_d = '0;
        valid_d = 1'b0;
        end_d = 1'b0;
        crcBad_d = 1'b0;
        rxErr_d = 1'b0;
        frames_d = frames_q;
        bad_d = bad_q;
        if (ok && |keep)
        begin
            data_d = rx.beat.data;
            ctl_d = keepNonPayload ? rx.beat.ctl : '0;
            keep_d = keep;
            first_d = rx.beat.first & keep;
            last_d = rx.beat.last;
            hit_d = rx.beat.dstHit & keep;
            runt_d = rx.beat.runt;
            valid_d = 1'b1;
        end
        if (ok && |rx.beat.last)
        begin
            end_d = 1'b1;
            crcBad_d = rx.beat.fcsValid && rx.beat.fcsError;
            rxErr_d = rx.beat.rxError;
            frames_d = 16'(frames_q + 16'h0001);
            if (crcBad_d || rx.beat.rxError)
                bad_d = 16'(bad_q + 16'h0001);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            data_q <= '0;
            ctl_q <= '0;
            keep_q <= '0;
            first_q <= '0;
            last_q <= '0;
            hit_q <= '0;
            runt_q <= '0;
            valid_q <= 1'b0;
            end_q <= 1'b0;
            crcBad_q <= 1'b0;
            rxErr_q <= 1'b0;
            frames_q <= 16'h0000;
            bad_q <= 16'h0000;
        end
        else
        begin
            data_q <= data_d;
            ctl_q <= ctl_d;
            keep_q <= keep_d;
            first_q <= first_d;
            last_q <= last_d;
            hit_q <= hit_d;
            runt_q <= runt_d;
            valid_q <= valid_d;
            end_q <= end_d;
            crcBad_q <= crcBad_d;
            rxErr_q <= rxErr_d;
            frames_q <= frames_d;
            bad_q <= bad_d;
        end
    end

    assign usrData = data_q;
    assign usrCtl = ctl_q;
    assign usrKeep = keep_q;
    assign usrFirst = first_q;
    assign usrLast = last_q;
    assign usrDestHit = hit_q;
    assign usrRunt = runt_q;
    assign usrValid = valid_q;
    assign usrFrameEnd = end_q;
    assign usrCrcBad = crcBad_q;
    assign usrRxError = rxErr_q;
    assign usrFrameCount = frames_q;
    assign usrBadCount = bad_q;
endmodule

/* File: rtl/ercs_if.sv */
// interface joining the mac end and the client end
`timescale 1ns/100ps
interface ercs_if;
    ercs_pkg::ercs_beat_type beat;
    modport mac (output beat);
    modport client (input beat);
endinterface

/* File: rtl/ercs_mac_end.sv */
// receive mac end: decodes the line, marks frames and drives the client stream
// Operation
// - five 64-bit words per cycle, two for 40G
// - own rx clock, unrelated to transmit clock
// - control flag per byte: idle/start 1
// - idle bytes show 07 with flag set
// - first-word marker on preamble or first data
// - frames begin at word most significant byte
// - last-byte marker on byte before fcs
// - short-frame flag below 64, not eight or fewer
// - payload flag on any word with frame data
// - crc error beside the last-byte marker
// - crc error qualified by its valid bit
// - crc correct for frames of 40 to 63
// - destination hit with filter bit overrides
// - valid almost always high, others ignored otherwise
// - pass-through shows start, preamble, sfd as given; start here shows as 55 with flag set
// - rx error on abort, crc, errors, length
// - client may drop words without payload
`timescale 1ns/100ps
`include "ercs_cfg.svh"
module ercs_mac_end (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // line side, byte N-1 first in time
    input wire logic [`ERCS_BYTES*8-1:0] lnData,
    input wire logic [`ERCS_BYTES-1:0] lnCtl,
    input wire logic lnValid,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    // interrupt
    output logic irq,
    // client stream
    ercs_if.mac rx
);
    localparam int NB = `ERCS_BYTES;
    localparam int NW = `ERCS_WORDS;

    ercs_pkg::ercs_scan_type scan_q, scan_d;
    ercs_pkg::ercs_stage_type stage_q, stage_d;
    ercs_pkg::ercs_beat_type beat_q, beat_d;
    logic [31:0] filter_q, filter_d, addrLow_q, addrLow_d, addrHigh_q, addrHigh_d;
    logic [15:0] maxLen_q, maxLen_d;
    logic pass_q, pass_d;
    logic [`ERCS_ST_BITS-1:0] status_q, status_d, mask_q, mask_d, events;
    logic [31:0] rdData_q, rdData_d;
    logic [2:0] preLeft;
    logic [7:0] byteVal;
    logic byteCtl;
    logic [2*NB-1:0] termWin;
    logic [2*NB*8-1:0] winData;
    logic fromCur, lastAny, runtEnd, longEnd, decodeEnd;
    logic [15:0] endLen;
    logic endCrcBad, endErr;

    function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int k = 0; k < 8; k++)
        begin
            r = r[0] ? ((r >> 1) ^ `ERCS_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic dstMatch(input logic [63:0] word, input logic [31:0] ctrl,
                                      input logic [31:0] lo, input logic [31:0] hi);
        if (!ctrl[`ERCS_FLT_ENA_BIT])
            return 1'b1;
        else if (!ctrl[`ERCS_FLT_CMP_BIT])
            return 1'b0;
        return word[63:16] == {hi[15:0], lo};
    endfunction

    // line decode: classify every byte of the incoming beat
    always_comb
    begin
        scan_d = scan_q;
        stage_d = stage_q;
        preLeft = 3'h0;
        byteVal = 8'h00;
        byteCtl = 1'b0;
        if (lnValid)
        begin
            stage_d.data = lnData;
            stage_d.start = '0;
            stage_d.term = '0;
            stage_d.body = '0;
            stage_d.pre = '0;
            stage_d.startW = '0;
            stage_d.firstW = '0;
            stage_d.abort = 1'b0;
            stage_d.stray = 1'b0;
            for (int b = NB - 1; b >= 0; b--)
            begin
                byteVal = lnData[b*8 +: 8];
                byteCtl = lnCtl[b];
                // start only counts at a word's top byte
                if (byteCtl && byteVal == `ERCS_CH_START && (b % 8) == 7)
                begin
                    if (scan_d.frame == ercs_pkg::ERCS_FR_BODY || preLeft != 3'h0)
                        stage_d.abort = 1'b1;
                    stage_d.start[b] = 1'b1;
                    stage_d.startW[b/8] = 1'b1;
                    preLeft = `ERCS_PRE_BYTES;
                    scan_d.frame = ercs_pkg::ERCS_FR_IDLE;
                    scan_d.fresh = 1'b1;
                    scan_d.crc = `ERCS_CRC_INIT;
                    scan_d.len = 16'h0000;
                    scan_d.err = 1'b0;
                end
                else if (preLeft != 3'h0)
                begin
                    stage_d.pre[b] = 1'b1;
                    preLeft = 3'(preLeft - 3'h1);
                    if (preLeft == 3'h0)
                        scan_d.frame = ercs_pkg::ERCS_FR_BODY;
                end
                else if (scan_d.frame == ercs_pkg::ERCS_FR_BODY)
                begin
                    if (byteCtl && byteVal == `ERCS_CH_TERM)
                    begin
                        stage_d.term[b] = 1'b1;
                        stage_d.endLen = scan_d.len;
                        stage_d.endCrcBad = scan_d.crc != `ERCS_CRC_RESIDUE;
                        stage_d.endErr = scan_d.err;
                        scan_d.frame = ercs_pkg::ERCS_FR_IDLE;
                    end
                    else
                    begin
                        stage_d.body[b] = 1'b1;
                        if (byteCtl)
                            scan_d.err = 1'b1;
                        scan_d.crc = crcByte(scan_d.crc, byteVal);
                        scan_d.len = 16'(scan_d.len + 16'h0001);
                        if (scan_d.fresh)
                            stage_d.firstW[b/8] = 1'b1;
                        scan_d.fresh = 1'b0;
                    end
                end
                else if (byteCtl && byteVal == `ERCS_CH_ERROR)
                    stage_d.stray = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scan_q <= '0;
            stage_q <= '0;
        end
        else
        begin
            scan_q <= scan_d;
            stage_q <= stage_d;
        end
    end

    // beat build: older beat in stage_q, newer decode in stage_d
    always_comb
    begin
        termWin = {stage_q.term, stage_d.term};
        winData = {stage_q.data, stage_d.data};
        beat_d = '0;
        beat_d.valid = lnValid;
        for (int i = 0; i < NB; i++)
        begin
            // four fcs bytes and the term follow the marked byte, so the term may sit one beat later
            beat_d.last[i] = termWin[i + NB - 5];
            if (stage_q.body[i])
            begin
                beat_d.data[i*8 +: 8] = stage_q.data[i*8 +: 8];
                beat_d.ctl[i] = 1'b0;
            end
            else if (pass_q && stage_q.pre[i])
            begin
                beat_d.data[i*8 +: 8] = stage_q.data[i*8 +: 8];
                beat_d.ctl[i] = 1'b0;
            end
            else if (pass_q && stage_q.start[i])
            begin
                beat_d.data[i*8 +: 8] = `ERCS_CH_PRE;
                beat_d.ctl[i] = 1'b1;
            end
            else
            begin
                beat_d.data[i*8 +: 8] = `ERCS_CH_IDLE;
                beat_d.ctl[i] = 1'b1;
            end
        end
        // one frame end per beat is reported; a second short end in the same beat shares it
        fromCur = |beat_d.last[4:0];
        lastAny = |beat_d.last;
        endLen = fromCur ? stage_d.endLen : stage_q.endLen;
        endCrcBad = fromCur ? stage_d.endCrcBad : stage_q.endCrcBad;
        endErr = fromCur ? stage_d.endErr : stage_q.endErr;
        runtEnd = lastAny && endLen < `ERCS_MIN_LEN && endLen > `ERCS_DECODE_LEN;
        longEnd = lastAny && endLen > maxLen_q;
        decodeEnd = (lastAny && (endLen <= `ERCS_DECODE_LEN || endErr)) || stage_q.abort || stage_q.stray;
        for (int w = 0; w < NW; w++)
        begin
            beat_d.first[w] = pass_q ? stage_q.startW[w] : stage_q.firstW[w];
            beat_d.payload[w] = |(stage_q.body[w*8 +: 8]
                | (pass_q ? (stage_q.pre[w*8 +: 8] | stage_q.start[w*8 +: 8]) : 8'h00));
            beat_d.runt[w] = runtEnd && |beat_d.last[w*8 +: 8];
            beat_d.dstHit[w] = beat_d.first[w]
                && dstMatch(winData[(w + NW - (pass_q ? 1 : 0))*64 +: 64], filter_q, addrLow_q, addrHigh_q);
        end
        beat_d.fcsValid = lastAny;
        beat_d.fcsError = lastAny && endCrcBad;
        beat_d.rxError = (lastAny && endCrcBad) || runtEnd || longEnd || decodeEnd;
        if (!lnValid)
            beat_d.rxError = 1'b0;
        events = '0;
        events[`ERCS_ST_CRC] = lnValid && lastAny && endCrcBad;
        events[`ERCS_ST_RUNT] = lnValid && runtEnd;
        events[`ERCS_ST_LONG] = lnValid && longEnd;
        events[`ERCS_ST_DECODE] = lnValid && decodeEnd;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            beat_q <= '0;
        else
            beat_q <= beat_d;
    end

    assign rx.beat = beat_q;

    // register port, reads answer one cycle later
    always_comb
    begin
        filter_d = filter_q;
        addrLow_d = addrLow_q;
        addrHigh_d = addrHigh_q;
        maxLen_d = maxLen_q;
        pass_d = pass_q;
        mask_d = mask_q;
        status_d = status_q;
        if (regWr)
        begin
            case (regAddr)
                `ERCS_REG_FILTER: filter_d = regWrData;
                `ERCS_REG_ADDR_LOW: addrLow_d = regWrData;
                `ERCS_REG_ADDR_HIGH: addrHigh_d = {16'h0000, regWrData[15:0]};
                `ERCS_REG_MAXLEN: maxLen_d = regWrData[15:0];
                `ERCS_REG_MODE: pass_d = regWrData[`ERCS_MODE_PASS_BIT];
                `ERCS_REG_STATUS: status_d = status_q & ~regWrData[`ERCS_ST_BITS-1:0];
                `ERCS_REG_MASK: mask_d = regWrData[`ERCS_ST_BITS-1:0];
                default: ;
            endcase
        end
        // a new event beats a clear in the same cycle
        status_d = status_d | events;
        rdData_d = 32'h00000000;
        if (regRd)
        begin
            case (regAddr)
                `ERCS_REG_FILTER: rdData_d = filter_q;
                `ERCS_REG_ADDR_LOW: rdData_d = addrLow_q;
                `ERCS_REG_ADDR_HIGH: rdData_d = addrHigh_q;
                `ERCS_REG_MAXLEN: rdData_d = {16'h0000, maxLen_q};
                `ERCS_REG_MODE: rdData_d = {31'h00000000, pass_q};
                `ERCS_REG_STATUS: rdData_d = {28'h0000000, status_q};
                `ERCS_REG_MASK: rdData_d = {28'h0000000, mask_q};
                default: rdData_d = 32'h00000000;
            endcase
        end
    end

    // the whole mac end runs on the rx clock only
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            filter_q <= 32'h00000000;
            addrLow_q <= 32'h00000000;
            addrHigh_q <= 32'h00000000;
            maxLen_q <= `ERCS_MAXLEN_RST;
            pass_q <= 1'b0;
            status_q <= '0;
            mask_q <= '0;
            rdData_q <= 32'h00000000;
        end
        else
        begin
            filter_q <= filter_d;
            addrLow_q <= addrLow_d;
            addrHigh_q <= addrHigh_d;
            maxLen_q <= maxLen_d;
            pass_q <= pass_d;
            status_q <= status_d;
            mask_q <= mask_d;
            rdData_q <= rdData_d;
        end
    end

    assign regRdData = rdData_q;
    assign irq = |(status_q & mask_q);
endmodule

/* File: rtl/ercs_pkg.sv */
// types of the receive client stream; the beat type is shared by both ends, the rest are mac end only
package ercs_pkg;
`include "ercs_cfg.svh"
    typedef enum logic [0:0] {ERCS_FR_IDLE = 1'b0, ERCS_FR_BODY = 1'b1} ercs_frame_type;

    typedef struct packed {
        logic [`ERCS_BYTES*8-1:0] data;
        logic [`ERCS_BYTES-1:0] ctl;
        logic [`ERCS_WORDS-1:0] first;
        logic [`ERCS_BYTES-1:0] last;
        logic [`ERCS_WORDS-1:0] runt;
        logic [`ERCS_WORDS-1:0] payload;
        logic [`ERCS_WORDS-1:0] dstHit;
        logic fcsError;
        logic fcsValid;
        logic rxError;
        logic valid;
    } ercs_beat_type;

    typedef struct packed {
        logic [`ERCS_BYTES*8-1:0] data;
        logic [`ERCS_BYTES-1:0] start;
        logic [`ERCS_BYTES-1:0] term;
        logic [`ERCS_BYTES-1:0] body;
        logic [`ERCS_BYTES-1:0] pre;
        logic [`ERCS_WORDS-1:0] startW;
        logic [`ERCS_WORDS-1:0] firstW;
        logic [15:0] endLen;
        logic endCrcBad;
        logic endErr;
        logic abort;
        logic stray;
    } ercs_stage_type;

    typedef struct packed {
        ercs_frame_type frame;
        logic fresh;
        logic [31:0] crc;
        logic [15:0] len;
        logic err;
    } ercs_scan_type;
endpackage

/* File: tb/ercs_assertions.sv */
// concurrent checks on the stream between the mac end and the client end
`timescale 1ns/100ps
`include "ercs_cfg.svh"
module ercs_assertions (
    // clock and reset
    input logic clk_sys,
    input logic rst,
    // stream between the two ends
    input ercs_pkg::ercs_beat_type beat
);
    logic [`ERCS_WORDS-1:0] lastW;
    logic [`ERCS_WORDS-1:0] idleBad;
    logic [`ERCS_WORDS-1:0] firstBad;

    // per-word summaries, so each property stays a plain relation
    always_comb
    begin
        for (int w = 0; w < `ERCS_WORDS; w++)
        begin
            lastW[w] = |beat.last[w*8 +: 8];
            idleBad[w] = !beat.payload[w] && (beat.ctl[w*8 +: 8] != 8'hff || beat.data[w*64 +: 64] != {8{8'h07}});
            firstBad[w] = beat.first[w] && (beat.ctl[w*8 +: 7] != 7'h00
                || (beat.ctl[w*8+7] && beat.data[w*64+56 +: 8] != 8'h55));
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    idle_word_a: assert property (beat.valid |-> idleBad == '0)
        else $error("word without payload is not shown as idle");
    first_word_a: assert property (beat.valid && |beat.first |-> firstBad == '0)
        else $error("first word has wrong control flags");
    first_payload_a: assert property (beat.valid |-> (beat.first & ~beat.payload) == '0)
        else $error("first word without payload flag");
    last_single_a: assert property (beat.valid |-> $onehot0(beat.last) && (beat.last & beat.ctl) == '0)
        else $error("last marker count or flag wrong");
    fcs_qual_a: assert property (beat.valid |-> beat.fcsValid == |beat.last)
        else $error("crc qualifier not beside the last marker");
    fcs_error_a: assert property (beat.valid && beat.fcsError |-> beat.fcsValid && beat.rxError)
        else $error("crc error without qualifier or receive error");
    runt_end_a: assert property (beat.valid && |beat.runt |-> (beat.runt & ~lastW) == '0 && beat.rxError)
        else $error("short-frame flag away from the frame end");
    dst_first_a: assert property (beat.valid |-> (beat.dstHit & ~beat.first) == '0)
        else $error("destination hit off the first word");
    valid_gap_a: assert property (!beat.valid |=> beat.valid)
        else $error("valid low for more than one cycle");
endmodule

/* File: tb/eth_rx_client_stream_tb_top.sv */
// self-checking bench joining the mac end and the client end
`timescale 1ns/100ps
`include "ercs_cfg.svh"
module eth_rx_client_stream_tb_top;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [`ERCS_BYTES*8-1:0] lnData = {`ERCS_BYTES{8'h07}};
    logic [`ERCS_BYTES-1:0] lnCtl = '1;
    logic lnValid = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic keepNonPayload = 1'b0;
    logic [31:0] regRdData;
    logic irq;
    logic [`ERCS_BYTES*8-1:0] usrData;
    logic [`ERCS_BYTES-1:0] usrCtl, usrLast;
    logic [`ERCS_WORDS-1:0] usrKeep, usrFirst, usrDestHit, usrRunt;
    logic usrValid, usrFrameEnd, usrCrcBad, usrRxError;
    logic [15:0] usrFrameCount, usrBadCount;
    int err_total = 0;
    int check_count = 0;
    int cycles = 0;
    int frames = 0;
    int maxLen = 1518;
    int bads = 0;
    logic [8:0] lineQ[$];
    logic [3:0] resQ[$];
    logic [31:0] rdQ[$];
    logic rdPend = 1'b0;
    logic hitV = 1'b0;
    logic [7:0] expTop = 8'h00;
    logic [7:0] expLast = 8'h00;
    logic [47:0] ourAddr = 48'h0211_2233_4455;
    logic [31:0] flt[4] = '{32'h0, 32'h40000000, 32'h40000001, 32'h00000001};
    int lens[7] = '{8, 9, 20, 39, 40, 63, 64};

    ercs_if rxLink ();
    ercs_mac_end ercs_mac_end_inst (.clk_sys(clk_sys), .rst(rst), .lnData(lnData), .lnCtl(lnCtl),
        .lnValid(lnValid), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .irq(irq), .rx(rxLink.mac));
    ercs_client_end ercs_client_end_inst (.clk_sys(clk_sys), .rst(rst), .rx(rxLink.client),
        .keepNonPayload(keepNonPayload), .usrData(usrData), .usrCtl(usrCtl), .usrKeep(usrKeep),
        .usrFirst(usrFirst), .usrLast(usrLast), .usrDestHit(usrDestHit), .usrRunt(usrRunt),
        .usrValid(usrValid), .usrFrameEnd(usrFrameEnd), .usrCrcBad(usrCrcBad), .usrRxError(usrRxError),
        .usrFrameCount(usrFrameCount), .usrBadCount(usrBadCount));
    ercs_assertions ercs_assertions_inst (.clk_sys(clk_sys), .rst(rst), .beat(rxLink.beat));

    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        if (err_total == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one register access; a read notes its expected data for the monitor
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWr <= w;
        regRd <= !w;
        if (!w)
            rdQ.push_back(d);
        @(posedge clk_sys);
        regWr <= 1'b0;
        regRd <= 1'b0;
    endtask

    // collects line characters, first in time at the bus top, and sends whole beats
    task automatic put(input logic c, input logic [7:0] b);
        lineQ.push_back({c, b});
        if (lineQ.size() == `ERCS_BYTES)
        begin
            @(posedge clk_sys);
            if ($urandom % 8 == 0)
            begin
                lnValid <= 1'b0;
                @(posedge clk_sys);
            end
            for (int i = 0; i < `ERCS_BYTES; i++)
            begin
                lnCtl[`ERCS_BYTES-1-i] <= lineQ[i][8];
                lnData[(`ERCS_BYTES-1-i)*8 +: 8] <= lineQ[i][7:0];
            end
            lnValid <= 1'b1;
            lineQ.delete();
        end
    endtask

    // len counts body and fcs; frames start on a random word, ends padded to a beat
    task automatic frame(input int len, input logic bad, input logic match, input logic hit, input logic pass);
        logic [7:0] body[$];
        logic [31:0] c;
        repeat (($urandom % `ERCS_WORDS) * 8)
            put(1'b1, 8'h07);
        for (int i = 0; i < len - 4; i++)
            body.push_back(i < 6 ? ourAddr[47-8*i -: 8] ^ {7'h00, (i == 5) && !match} : 8'($urandom));
        c = 32'hffffffff;
        foreach (body[i])
        begin
            c = c ^ {24'h000000, body[i]};
            repeat (8)
                c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
        end
        c = ~c ^ {31'h0, bad};
        for (int i = 0; i < 4; i++)
            body.push_back(c[8*i +: 8]);
        resQ.push_back({hit, bad, len > 8 && len < 64, bad || len < 64 || len > maxLen});
        bads += int'(bad || len < 64 || len > maxLen);
        expTop = pass ? 8'h55 : body[0];
        expLast = body[len - 5];
        put(1'b1, 8'hfb);
        repeat (6)
            put(1'b0, 8'h55);
        put(1'b0, 8'hd5);
        foreach (body[i])
            put(1'b0, body[i]);
        put(1'b1, 8'hfd);
        while (lineQ.size() != 0)
            put(1'b1, 8'h07);
        repeat (`ERCS_BYTES)
            put(1'b1, 8'h07);
        frames++;
        repeat (6) @(posedge clk_sys);
    endtask

    // watches the stream and the user side, checking the oldest notes
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            tally_and_finish();
        end
        if (!rst)
        begin
            if (usrValid && |usrFirst)
                hitV = |(usrDestHit & usrFirst);
            if (usrFrameEnd)
                chk({28'h0, hitV, usrCrcBad, |usrRunt, usrRxError},
                    resQ.size() != 0 ? {28'h0, resQ.pop_front()} : '1);
            if (usrValid && !keepNonPayload)
                chk({31'h0, |usrCtl}, 32'h0);
            for (int i = 0; i < `ERCS_BYTES; i++)
                if (usrValid && usrLast[i])
                    chk({24'h0, usrData[i*8 +: 8]}, {24'h0, expLast});
            if (rdPend)
                chk(regRdData, rdQ.pop_front());
            rdPend = regRd;
            for (int w = 0; w < `ERCS_WORDS; w++)
                if (rxLink.beat.valid && rxLink.beat.first[w])
                    chk({24'h0, rxLink.beat.data[w*64+56 +: 8]}, {24'h0, expTop});
        end
    end

    initial
    begin
        void'($urandom(32'hfe759958));
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        acc(1'b0, `ERCS_REG_MAXLEN, 32'h000005ee);
        acc(1'b0, `ERCS_REG_FILTER, 32'h0);
        acc(1'b1, 8'h40, 32'hffffffff);
        acc(1'b0, 8'h40, 32'h0);
        acc(1'b1, `ERCS_REG_ADDR_LOW, ourAddr[31:0]);
        acc(1'b1, `ERCS_REG_ADDR_HIGH, {16'h0, ourAddr[47:32]});
        acc(1'b0, `ERCS_REG_ADDR_HIGH, {16'h0, ourAddr[47:32]});
        foreach (flt[k])
            for (int m = 0; m < 2; m++)
            begin
                acc(1'b1, `ERCS_REG_FILTER, flt[k]);
                frame(64 + $urandom % 100, 1'b0, m[0], !flt[k][30] || (flt[k][0] && m[0]), 1'b0);
            end
        foreach (lens[i])
            frame(lens[i], 1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b1, `ERCS_REG_STATUS, 32'hf);
        frame(80, 1'b1, 1'b1, 1'b1, 1'b0);
        acc(1'b0, `ERCS_REG_STATUS, 32'h1);
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, `ERCS_REG_MASK, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, `ERCS_REG_STATUS, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        frame(45, 1'b1, 1'b1, 1'b1, 1'b0);
        maxLen = 100;
        acc(1'b1, `ERCS_REG_MAXLEN, 32'h00000064);
        acc(1'b1, `ERCS_REG_STATUS, 32'hf);
        frame(100, 1'b0, 1'b1, 1'b1, 1'b0);
        frame(101, 1'b0, 1'b1, 1'b1, 1'b0);
        acc(1'b0, `ERCS_REG_STATUS, 32'h4);
        maxLen = 1518;
        acc(1'b1, `ERCS_REG_MAXLEN, 32'h000005ee);
        keepNonPayload <= 1'b1;
        acc(1'b1, `ERCS_REG_MODE, 32'h1);
        frame(70, 1'b0, 1'b1, 1'b1, 1'b1);
        frame(64, 1'b1, 1'b1, 1'b1, 1'b1);
        acc(1'b1, `ERCS_REG_MODE, 32'h0);
        chk({16'h0, usrFrameCount}, 32'(frames));
        chk({16'h0, usrBadCount}, 32'(bads));
        tally_and_finish();
    end
endmodule
